/* bench/serial_link_tx.sv */
`timescale 1ns/1ps
// ----------------------------------------
// serial link transmitter model
// ----------------------------------------
// clock stands still between bursts; unused pair carries the inverted bit
module serial_link_tx (
	output logic o_bit_clk,
	output logic o_primary,
	output logic o_secondary
);
	initial
	begin
		o_bit_clk = 1'b0;
		o_primary = 1'b0;
		o_secondary = 1'b1;
	end

	// ten bits per character, first bit a, data moves while clock is low
	task automatic send_char(input logic [9:0] code, input logic use_primary);
		#1.7;
		for (int i = 9; i >= 0; i--)
		begin
			o_primary = use_primary ? code[i] : ~code[i];
			o_secondary = use_primary ? ~code[i] : code[i];
			#24;
			o_bit_clk = 1'b1;
			#24;
			o_bit_clk = 1'b0;
		end
	endtask : send_char
endmodule : serial_link_tx

/* bench/tb_serial_rx_parallel_output.sv */
`timescale 1ns/1ps
module tb_serial_rx_parallel_output;
	typedef struct {logic [9:0] code; logic raw; logic sel; logic [10:0] exp; logic [10:0] care;} row_t;
	logic i_clk_sys, i_rst, i_link_bit_clk, i_serial_in_primary, i_serial_in_secondary;
	logic i_input_select, i_mode_unencoded, i_self_test_enable_n, i_reg_wr, i_reg_rd;
	logic [3:0] i_reg_addr;
	logic [31:0] i_reg_wdata, o_reg_rdata, rd;
	logic o_irq, o_control_char_flag, o_code_violation_flag, o_data_ready_n, o_recovered_byte_clock;
	logic [7:0] o_received_byte, prev_byte;
	logic prev_clk;
	int n_errors = 0;
	int samples_checked = 0;
	row_t rows [7];
	logic [9:0] st_codes [5] = '{10'h0FA, 10'h2AA, 10'h274, 10'h1D4, 10'h274};
	logic [10:0] st_exp [5] = '{11'h001, 11'h001, 11'h000, 11'h008, 11'h002};
	logic [10:0] st_care [5] = '{11'h001, 11'h001, 11'h7FF, 11'h7FF, 11'h003};

	// ----------------------------------------
	// design and link partner
	// ----------------------------------------
	serial_rx_output dut_u (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_link_bit_clk(i_link_bit_clk),
		.i_serial_in_primary(i_serial_in_primary), .i_serial_in_secondary(i_serial_in_secondary),
		.i_input_select(i_input_select), .i_mode_unencoded(i_mode_unencoded),
		.i_self_test_enable_n(i_self_test_enable_n), .i_reg_addr(i_reg_addr),
		.i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
		.o_reg_rdata(o_reg_rdata), .o_irq(o_irq), .o_received_byte(o_received_byte),
		.o_control_char_flag(o_control_char_flag), .o_code_violation_flag(o_code_violation_flag),
		.o_data_ready_n(o_data_ready_n), .o_recovered_byte_clock(o_recovered_byte_clock));
	serial_link_tx partner_u (.o_bit_clk(i_link_bit_clk), .o_primary(i_serial_in_primary),
		.o_secondary(i_serial_in_secondary));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task fail(input logic [31:0] got, input logic [31:0] exp);
		n_errors++;
		$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
	endtask : fail

	task chk32(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
			fail(got, exp);
	endtask : chk32

	// byte, qualifier, violation and ready compared under a care mask
	task chk_char(input logic [10:0] exp, input logic [10:0] care);
		logic [10:0] got;
		got = {o_received_byte, o_control_char_flag, o_code_violation_flag, o_data_ready_n};
		samples_checked++;
		if ((got & care) !== (exp & care))
			fail({21'h0, got}, {21'h0, exp});
	endtask : chk_char

	task reg_write(input logic [3:0] a, input logic [31:0] d);
		@(posedge i_clk_sys);
		i_reg_addr <= a;
		i_reg_wdata <= d;
		i_reg_wr <= 1'b1;
		@(posedge i_clk_sys);
		i_reg_wr <= 1'b0;
	endtask : reg_write

	// read data stands only in the cycle after the strobe
	task reg_read(input logic [3:0] a, output logic [31:0] d);
		@(posedge i_clk_sys);
		i_reg_addr <= a;
		i_reg_rd <= 1'b1;
		@(posedge i_clk_sys);
		i_reg_rd <= 1'b0;
		#1;
		d = o_reg_rdata;
	endtask : reg_read

	// host captures on the rising byte clock
	task wait_char;
		int k;
		logic last;
		k = 0;
		last = o_recovered_byte_clock;
		@(posedge i_clk_sys);
		#1;
		while (!(last === 1'b0 && o_recovered_byte_clock === 1'b1) && k < 4000)
		begin
			last = o_recovered_byte_clock;
			@(posedge i_clk_sys);
			#1;
			k++;
		end
		if (k >= 4000)
			fail(32'h0, 32'h1);
	endtask : wait_char

	// raw mode: byte {h,g,f,i,e,d,c,b}, qualifier a, violation j, ready low
	function automatic logic [10:0] raw_exp(input logic [9:0] c);
		return {c[1], c[2], c[3], c[4], c[5], c[6], c[7], c[8], c[9], c[0], 1'b0};
	endfunction : raw_exp

	task results;
		$display("checked %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : results

	// ----------------------------------------
	// clock, watchdog and edge monitor
	// ----------------------------------------
	initial
	begin
		i_clk_sys = 1'b0;
		forever #2.5 i_clk_sys = ~i_clk_sys;
	end

	initial
	begin
		#200000;
		n_errors++;
		results();
	end

	// the received byte may only move together with a rising byte clock
	always @(posedge i_clk_sys)
	begin
		#1;
		if (!i_rst && o_received_byte !== prev_byte)
		begin
			samples_checked++;
			if (!(o_recovered_byte_clock === 1'b1 && prev_clk === 1'b0))
				fail({24'h0, o_received_byte}, {24'h0, prev_byte});
		end
		prev_byte = o_received_byte;
		prev_clk = o_recovered_byte_clock;
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		i_rst = 1'b1;
		i_input_select = 1'b1;
		i_mode_unencoded = 1'b0;
		i_self_test_enable_n = 1'b1;
		i_reg_addr = 4'h0;
		i_reg_wdata = 32'h0;
		i_reg_wr = 1'b0;
		i_reg_rd = 1'b0;
		rows[0] = '{10'h2AA, 1'b0, 1'b1, {8'hB5, 3'h0}, 11'h7FF};
		rows[1] = '{10'h155, 1'b0, 1'b0, {8'h4A, 3'h0}, 11'h7FF};
		rows[2] = '{10'h0F4, 1'b0, 1'b1, {8'h1C, 3'h4}, 11'h7FF};
		rows[3] = '{10'h0FA, 1'b0, 1'b0, {8'hBC, 3'h5}, 11'h7FF};
		rows[4] = '{10'h2A0, 1'b0, 1'b1, 11'h002, 11'h002};
		rows[5] = '{10'h274, 1'b1, 1'b0, raw_exp(10'h274), 11'h7FF};
		rows[6] = '{10'h0F5, 1'b1, 1'b1, raw_exp(10'h0F5), 11'h7FF};
		repeat (10) @(posedge i_clk_sys);
		i_rst <= 1'b0;
		#1;
		chk_char(11'h001, 11'h7FF);
		chk32({31'h0, o_recovered_byte_clock | o_irq}, 32'h0);
		reg_read(4'h0, rd);
		chk32(rd, 32'h0);
		reg_read(4'h4, rd);
		chk32(rd, 32'h0);
		$display("reset test done");
		// each row: comma for framing, then the character under test
		foreach (rows[i])
		begin
			@(posedge i_clk_sys);
			i_mode_unencoded <= rows[i].raw;
			i_input_select <= rows[i].sel;
			repeat (10) @(posedge i_clk_sys);
			fork
				begin
					partner_u.send_char(10'h0FA, rows[i].sel);
					partner_u.send_char(rows[i].code, rows[i].sel);
				end
			join_none
			wait_char;
			wait_char;
			chk_char(rows[i].exp, rows[i].care);
		end
		$display("character table done");
		// sticky events, mask, clear and unmapped address
		reg_read(4'h0, rd);
		chk32(rd, 32'h3);
		chk32({31'h0, o_irq}, 32'h0);
		reg_write(4'h4, 32'h2);
		repeat (2) @(posedge i_clk_sys);
		#1;
		chk32({31'h0, o_irq}, 32'h1);
		reg_write(4'h0, 32'h3);
		reg_read(4'h0, rd);
		chk32(rd, 32'h0);
		chk32({31'h0, o_irq}, 32'h0);
		reg_read(4'h4, rd);
		chk32(rd, 32'h2);
		reg_read(4'h8, rd);
		// last character raw 0F5: byte 5E, qualifier 0, violation 1, ready low, checker off
		chk32(rd, 32'h0001005E);
		reg_write(4'hC, 32'hFFFFFFFF);
		reg_read(4'hC, rd);
		chk32(rd, 32'h0);
		$display("register test done");
		// self-test: data before the start character is ignored, then pattern checking
		@(posedge i_clk_sys);
		i_mode_unencoded <= 1'b0;
		i_input_select <= 1'b1;
		i_self_test_enable_n <= 1'b0;
		repeat (10) @(posedge i_clk_sys);
		fork
			foreach (st_codes[j])
				partner_u.send_char(st_codes[j], 1'b1);
		join_none
		foreach (st_codes[j])
		begin
			wait_char;
			chk_char(st_exp[j], st_care[j]);
		end
		$display("self-test done");
		results();
	end
endmodule : tb_serial_rx_parallel_output

/* hdl/pin_sync.sv */
`timescale 1ns/1ps
// three-stage synchroniser; output moves once stages two and three agree
module pin_sync #(parameter int W = 1) (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	genvar g;
	generate
		for (g = 0; g < W; g++)
		begin : g_bit
			logic s1_reg, s2_reg, s3_reg;
			// stage one feeds only stage two
			always_ff @(posedge i_clk_sys or posedge i_rst)
			begin
				if (i_rst)
				begin
					s1_reg <= 1'b0;
					s2_reg <= 1'b0;
					s3_reg <= 1'b0;
					o_sync[g] <= 1'b0;
				end
				else
				begin
					s1_reg <= i_async[g];
					s2_reg <= s1_reg;
					s3_reg <= s2_reg;
					if (s2_reg == s3_reg)
						o_sync[g] <= s3_reg;
				end
			end
		end
	endgenerate
endmodule : pin_sync

/* hdl/rx_char_decoder.sv */
`timescale 1ns/1ps
// ten-bit line code to byte; bit 9 is the first bit on the line
module rx_char_decoder (
	input wire logic [9:0] i_code,
	output logic [7:0] o_byte,
	output logic o_ctrl,
	output logic o_viol
);
	// {valid, k28, value}
	function automatic logic [6:0] dec6(input logic [5:0] c);
		case (c)
			6'h27, 6'h18: dec6 = 7'h40;
			6'h1D, 6'h22: dec6 = 7'h41;
			6'h2D, 6'h12: dec6 = 7'h42;
			6'h31: dec6 = 7'h43;
			6'h35, 6'h0A: dec6 = 7'h44;
			6'h29: dec6 = 7'h45;
			6'h19: dec6 = 7'h46;
			6'h38, 6'h07: dec6 = 7'h47;
			6'h39, 6'h06: dec6 = 7'h48;
			6'h25: dec6 = 7'h49;
			6'h15: dec6 = 7'h4A;
			6'h34: dec6 = 7'h4B;
			6'h0D: dec6 = 7'h4C;
			6'h2C: dec6 = 7'h4D;
			6'h1C: dec6 = 7'h4E;
			6'h17, 6'h28: dec6 = 7'h4F;
			6'h1B, 6'h24: dec6 = 7'h50;
			6'h23: dec6 = 7'h51;
			6'h13: dec6 = 7'h52;
			6'h32: dec6 = 7'h53;
			6'h0B: dec6 = 7'h54;
			6'h2A: dec6 = 7'h55;
			6'h1A: dec6 = 7'h56;
			6'h3A, 6'h05: dec6 = 7'h57;
			6'h33, 6'h0C: dec6 = 7'h58;
			6'h26: dec6 = 7'h59;
			6'h16: dec6 = 7'h5A;
			6'h36, 6'h09: dec6 = 7'h5B;
			6'h0E: dec6 = 7'h5C;
			6'h2E, 6'h11: dec6 = 7'h5D;
			6'h1E, 6'h21: dec6 = 7'h5E;
			6'h2B, 6'h14: dec6 = 7'h5F;
			6'h0F, 6'h30: dec6 = 7'h7C;
			default: dec6 = 7'h00;
		endcase
	endfunction : dec6
	// {valid, alternate seven, value}
	function automatic logic [4:0] dec4(input logic [3:0] c);
		case (c)
			4'hB, 4'h4: dec4 = 5'h10;
			4'h9: dec4 = 5'h11;
			4'h5: dec4 = 5'h12;
			4'hC, 4'h3: dec4 = 5'h13;
			4'hD, 4'h2: dec4 = 5'h14;
			4'hA: dec4 = 5'h15;
			4'h6: dec4 = 5'h16;
			4'hE, 4'h1: dec4 = 5'h17;
			4'h7, 4'h8: dec4 = 5'h1F;
			default: dec4 = 5'h00;
		endcase
	endfunction : dec4
	wire logic [6:0] r6 = dec6(i_code[9:4]);
	// positive-disparity K28 carries its tail inverted
	wire logic [3:0] tail = (i_code[9:4] == 6'h30) ? ~i_code[3:0] : i_code[3:0];
	wire logic [4:0] r4 = dec4(tail);
	wire logic k_alt = r4[3] & (r6[4:0] == 5'h17 || r6[4:0] == 5'h1B
		|| r6[4:0] == 5'h1D || r6[4:0] == 5'h1E);
	assign o_byte = {r4[2:0], r6[4:0]};
	assign o_ctrl = r6[5] | k_alt;
	assign o_viol = ~(r6[6] & r4[4]);
endmodule : rx_char_decoder

/* hdl/serial_rx_defines.svh */
`ifndef SERIAL_RX_DEFINES_SVH
`define SERIAL_RX_DEFINES_SVH
// register offsets (byte addresses)
`define RX_REG_STATUS 4'h0
`define RX_REG_MASK 4'h4
`define RX_REG_CHAR 4'h8
// event bit positions in status and mask
`define RX_EV_CHAR 0
`define RX_EV_VIOL 1
`define RX_EV_LOOP 2
`define RX_EV_W 3
// reset values
`define RX_MASK_RST 3'h0
`define RX_STATUS_RST 3'h0
// character framing counts, in serial bits
`define RX_BIT_LAST 4'h9
`define RX_CLK_FALL_BIT 4'h4
// comma pattern in the first seven bits of a character
`define RX_COMMA_NEG 7'h1F
`define RX_COMMA_POS 7'h60
// special byte values
`define RX_NULL_BYTE 8'hBC
`define RX_LOOP_START 8'h00
`define RX_LOOP_LAST 8'hFF
`endif

/* hdl/serial_rx_output.sv */
`timescale 1ns/1ps
`include "serial_rx_defines.svh"
module serial_rx_output
	import serial_rx_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_link_bit_clk,
	input wire logic i_serial_in_primary,
	input wire logic i_serial_in_secondary,
	input wire logic i_input_select,
	input wire logic i_mode_unencoded,
	input wire logic i_self_test_enable_n,
	input wire logic [3:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [31:0] o_reg_rdata,
	output logic o_irq,
	output logic [7:0] o_received_byte,
	output logic o_control_char_flag,
	output logic o_code_violation_flag,
	output logic o_data_ready_n,
	output logic o_recovered_byte_clock
);
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic s_pri, s_sec, s_bclk, s_sel, s_unenc, s_test_n;
	pin_sync #(.W(6)) u_sync (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_async({i_serial_in_primary, i_serial_in_secondary, i_link_bit_clk,
			i_input_select, i_mode_unencoded, i_self_test_enable_n}),
		.o_sync({s_pri, s_sec, s_bclk, s_sel, s_unenc, s_test_n})
	);

	// ----------------------------------------
	// bit shifter and character framing
	// ----------------------------------------
	logic bclk_prev_reg;
	logic [9:0] shift_reg;
	logic [3:0] bit_cnt_reg;
	logic [9:0] code_reg;
	logic char_take_reg;
	// pick the active input and frame ten bits, realigning on a comma
	wire logic serial_bit = s_sel ? s_pri : s_sec;
	wire logic bit_edge = s_bclk & ~bclk_prev_reg;
	wire logic [9:0] shift_next = {shift_reg[8:0], serial_bit};
	wire logic comma_seen = (shift_next[9:3] == `RX_COMMA_NEG)
		|| (shift_next[9:3] == `RX_COMMA_POS);
	wire logic word_done = bit_edge & ((bit_cnt_reg == `RX_BIT_LAST) | comma_seen);
	wire logic [3:0] bit_cnt_next = word_done ? 4'h0
		: (bit_edge ? bit_cnt_reg + 4'h1 : bit_cnt_reg);

	// shifter runs on link bit edges; a full word is latched whole
	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			bclk_prev_reg <= 1'b0;
			shift_reg <= 10'h000;
			bit_cnt_reg <= 4'h0;
			code_reg <= 10'h000;
			char_take_reg <= 1'b0;
		end
		else
		begin
			bclk_prev_reg <= s_bclk;
			if (bit_edge)
				shift_reg <= shift_next;
			bit_cnt_reg <= bit_cnt_next;
			if (word_done)
				code_reg <= shift_next;
			char_take_reg <= word_done;
		end
	end

	// ----------------------------------------
	// decode and self-test checker
	// ----------------------------------------
	logic [7:0] dec_byte;
	logic dec_ctrl, dec_err;
	rx_char_decoder u_dec (
		.i_code(code_reg),
		.o_byte(dec_byte),
		.o_ctrl(dec_ctrl),
		.o_viol(dec_err)
	);
	test_state_t test_state, test_state_next;
	logic [7:0] loop_cnt_reg;
	// null fill is the comma control character
	wire logic dec_null = dec_ctrl & ~dec_err & (dec_byte == `RX_NULL_BYTE);
	wire logic dec_data_ok = ~s_unenc & ~dec_ctrl & ~dec_err;
	wire logic start_hit = dec_data_ok & (dec_byte == `RX_LOOP_START);
	wire logic check_match = dec_data_ok & (dec_byte == loop_cnt_reg);
	wire logic loop_last = (test_state == st_check) && (loop_cnt_reg == `RX_LOOP_LAST);
	// the byte after the loop-start character is expected to be one
	wire logic [7:0] loop_cnt_next = (test_state == st_check) ? loop_cnt_reg + 8'h01 : 8'h01;

	// checker waits for the loop-start character, then follows the count
	always_comb
	begin
		test_state_next = test_state;
		case (test_state)
			st_off: if (!s_test_n) test_state_next = st_wait;
			st_wait: if (char_take_reg && start_hit) test_state_next = st_check;
			st_check: test_state_next = st_check;
			default: test_state_next = st_off;
		endcase
		if (s_test_n)
			test_state_next = st_off;
	end

	// expected byte advances once per delivered character
	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			test_state <= st_off;
			loop_cnt_reg <= 8'h00;
		end
		else
		begin
			test_state <= test_state_next;
			if (char_take_reg)
				loop_cnt_reg <= loop_cnt_next;
		end
	end

	// ----------------------------------------
	// output selection
	// ----------------------------------------
	// raw order: byte {h,g,f,i,e,d,c,b}, qualifier a, violation j
	wire logic [7:0] raw_byte = {code_reg[1], code_reg[2], code_reg[3], code_reg[4],
		code_reg[5], code_reg[6], code_reg[7], code_reg[8]};
	wire logic [7:0] byte_next = s_unenc ? raw_byte : dec_byte;
	wire logic ctrl_next = s_unenc ? code_reg[9] : dec_ctrl;
	wire logic viol_next = s_unenc ? code_reg[0]
		: ((test_state == st_check) ? ~check_match : dec_err);
	wire logic rdy_n_next = s_unenc ? 1'b0
		: (test_state == st_check) ? loop_last
		: (test_state == st_wait) ? ~start_hit
		: dec_null;
	wire logic fall_pt = bit_edge & (bit_cnt_reg == `RX_CLK_FALL_BIT);

	// all character outputs move together with the byte clock rising edge
	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_received_byte <= 8'h00;
			o_control_char_flag <= 1'b0;
			o_code_violation_flag <= 1'b0;
			o_data_ready_n <= 1'b1;
			o_recovered_byte_clock <= 1'b0;
		end
		else
		begin
			if (char_take_reg)
			begin
				o_received_byte <= byte_next;
				o_control_char_flag <= ctrl_next;
				o_code_violation_flag <= viol_next;
				o_data_ready_n <= rdy_n_next;
			end
			if (char_take_reg)
				o_recovered_byte_clock <= 1'b1;
			else if (fall_pt)
				o_recovered_byte_clock <= 1'b0;
		end
	end

	// ----------------------------------------
	// register port and interrupt
	// ----------------------------------------
	logic [`RX_EV_W-1:0] status_reg, mask_reg;
	wire logic wr_status = i_reg_wr & (i_reg_addr == `RX_REG_STATUS);
	wire logic wr_mask = i_reg_wr & (i_reg_addr == `RX_REG_MASK);
	wire logic [`RX_EV_W-1:0] ev_now = {char_take_reg & loop_last,
		char_take_reg & viol_next, char_take_reg & ~rdy_n_next};
	wire logic [`RX_EV_W-1:0] st_clr = wr_status ? i_reg_wdata[`RX_EV_W-1:0] : 3'h0;
	// a new event wins over a write-one clear in the same cycle
	wire logic [`RX_EV_W-1:0] status_next = (status_reg & ~st_clr) | ev_now;
	wire logic [31:0] char_view = {12'h000, 2'(test_state), o_data_ready_n,
		o_code_violation_flag, o_control_char_flag, 7'h00, o_received_byte};
	wire logic [31:0] rd_mux = (i_reg_addr == `RX_REG_STATUS) ? {29'h0, status_reg}
		: (i_reg_addr == `RX_REG_MASK) ? {29'h0, mask_reg}
		: (i_reg_addr == `RX_REG_CHAR) ? char_view
		: 32'h00000000;

	// sticky status, mask, one-cycle read data and level interrupt
	always_ff @(posedge i_clk_sys or posedge i_rst)
	begin
		if (i_rst)
		begin
			status_reg <= `RX_STATUS_RST;
			mask_reg <= `RX_MASK_RST;
			o_reg_rdata <= 32'h00000000;
			o_irq <= 1'b0;
		end
		else
		begin
			status_reg <= status_next;
			if (wr_mask)
				mask_reg <= i_reg_wdata[`RX_EV_W-1:0];
			o_reg_rdata <= i_reg_rd ? rd_mux : 32'h00000000;
			o_irq <= |(status_reg & mask_reg);
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_rst);

	a_byte_hold: assert property ($changed(o_received_byte) |-> $rose(o_recovered_byte_clock))
		else $error("byte changed away from the byte clock edge");
	a_flag_timing: assert property (($changed(o_control_char_flag)
		|| $changed(o_code_violation_flag) || $changed(o_data_ready_n))
		|-> $rose(o_recovered_byte_clock))
		else $error("flag changed away from the byte clock edge");
	a_ctrl_qualifier: assert property (char_take_reg && !s_unenc
		|=> o_control_char_flag == $past(dec_ctrl))
		else $error("qualifier does not match decoded character");
	a_raw_bits: assert property (char_take_reg && s_unenc |=>
		o_received_byte[0] == $past(code_reg[8]) && o_received_byte[1] == $past(code_reg[7])
		&& o_received_byte[7] == $past(code_reg[1])
		&& o_control_char_flag == $past(code_reg[9])
		&& o_code_violation_flag == $past(code_reg[0]))
		else $error("raw bit placement wrong");
	a_viol_flag: assert property (char_take_reg && !s_unenc && test_state == st_off
		|=> o_code_violation_flag == $past(dec_err))
		else $error("violation flag does not follow decoder");
	a_test_pass: assert property (char_take_reg && test_state == st_check && check_match
		|=> !o_code_violation_flag)
		else $error("matching test byte flagged");
	a_null_gap: assert property (char_take_reg && !s_unenc && test_state == st_off
		|=> o_data_ready_n == $past(dec_null))
		else $error("ready wrong for null or data");
	a_loop_last: assert property (char_take_reg && test_state == st_check
		|=> o_data_ready_n == $past(loop_last))
		else $error("self-test ready wrong");
	a_clk_phase: assert property ($rose(o_recovered_byte_clock) |-> $past(word_done, 2))
		else $error("byte clock not aligned to a word boundary");
	a_input_route: assert property (bit_edge |=> shift_reg[0] == $past(s_sel ? s_pri : s_sec))
		else $error("wrong serial input shifted");
	a_start_wait: assert property (test_state == st_wait && !(char_take_reg && start_hit)
		|=> test_state != st_check)
		else $error("checking began without start character");
	a_bit_count: assert property (bit_cnt_reg <= `RX_BIT_LAST)
		else $error("bit counter past ten bits");

	// decoded and raw character delivery
	a_decoded_byte: assert property (char_take_reg && !s_unenc
		|=> o_received_byte == $past(dec_byte))
		else $error("decoded byte not delivered");
	a_raw_ready: assert property (char_take_reg && s_unenc
		|=> !o_data_ready_n)
		else $error("ready not low in unencoded mode");
	a_null_skip: assert property (char_take_reg && !s_unenc && test_state == st_off
		&& dec_null |=> o_data_ready_n)
		else $error("ready given for a null character");
	a_data_ready: assert property (char_take_reg && !s_unenc && test_state == st_off
		&& !dec_null |=> !o_data_ready_n)
		else $error("ready missing for a new character");
	a_outputs_hold: assert property (!char_take_reg |=> $stable(o_received_byte)
		&& $stable(o_control_char_flag) && $stable(o_code_violation_flag) && $stable(o_data_ready_n))
		else $error("character outputs moved between characters");

	// self-test progress
	a_test_fail: assert property (char_take_reg && test_state == st_check && !s_unenc
		&& !check_match |=> o_code_violation_flag)
		else $error("mismatching test byte not flagged");
	a_wait_ready: assert property (char_take_reg && test_state == st_wait && !s_unenc
		|=> o_data_ready_n == !$past(start_hit))
		else $error("ready wrong while waiting for loop start");
	a_check_start: assert property (test_state == st_wait && char_take_reg && start_hit
		&& !s_test_n |=> test_state == st_check)
		else $error("checking did not begin at the start character");
	a_test_exit: assert property (s_test_n |=> test_state == st_off)
		else $error("checker active with self-test disabled");

	// byte clock shape
	a_clk_rise: assert property (char_take_reg |=> o_recovered_byte_clock)
		else $error("byte clock did not rise with a character");
	a_clk_fall: assert property (fall_pt && !char_take_reg |=> !o_recovered_byte_clock)
		else $error("byte clock did not fall mid character");

	// sticky events and interrupt level
	a_status_set: assert property (|ev_now
		|=> (status_reg & $past(ev_now)) == $past(ev_now))
		else $error("event lost from status");
	a_irq_level: assert property (|(status_reg & mask_reg) |=> o_irq)
		else $error("interrupt low with an unmasked event");
	a_irq_quiet: assert property (!(|(status_reg & mask_reg)) |=> !o_irq)
		else $error("interrupt high with no unmasked event");
endmodule : serial_rx_output

/* hdl/serial_rx_pkg.sv */
package serial_rx_pkg;
	// self-test checker progress
	typedef enum logic [1:0] {st_off, st_wait, st_check} test_state_t;
endpackage : serial_rx_pkg
